// File: hw/smc_pkg.sv
package smc_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_OPERATION_CONTROL_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_DAC_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_P_GAIN      = 4'h2;
  localparam logic [3:0] ADDR_P_OFFS      = 4'h3;
  localparam logic [3:0] ADDR_T_GAIN      = 4'h4;
  localparam logic [3:0] ADDR_T_OFFS      = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT    = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h7;
  localparam logic [3:0] ADDR_FIFO_DATA   = 4'h8;
  localparam logic [3:0] ADDR_FIFO_LEVEL  = 4'h9;
  localparam logic [3:0] ADDR_P_RESULT    = 4'hA;
  localparam logic [3:0] ADDR_T_RESULT    = 4'hB;
  localparam logic [3:0] ADDR_DAC_VALUE   = 4'hC;

  // operation_control fields
  localparam int OP_DELAY_LSB   = 0;   // [3:0]
  localparam int OP_FIFO_MODE   = 4;   // [5:4]
  localparam int OP_THR_LSB     = 6;   // [10:6]
  localparam int OP_INT_CONT    = 11;
  localparam int OP_INT_MODE    = 12;
  // dac_output_control fields
  localparam int DAC_SEL_TEMP   = 0;
  localparam int DAC_BUF_CUR    = 1;

  localparam logic [15:0] OPERATION_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DAC_RESET  = 16'h0000;
  localparam logic [15:0] GAIN_ONE   = 16'h8000; // Q1.15 unity-ish
  localparam logic [15:0] OFFS_ZERO  = 16'h0000;
  localparam int          GAIN_FRAC  = 15;

  // fifo
  localparam int          FIFO_DEPTH = 32;
  localparam int          FIFO_AW    = 5;
  typedef enum logic [1:0] {
    SMC_FIFO_OFF  = 2'h0,
    SMC_FIFO_STOP = 2'h1,
    SMC_FIFO_OVWR = 2'h2
  } smc_fifo_mode_t;

  // interrupt status bits
  localparam int IRQ_FIFO_THR = 0;
  localparam int IRQ_MEAS     = 1;
  localparam int IRQ_OVFL     = 2;
  localparam int IRQ_W        = 3;

  // timing
  localparam longint CLK_HZ      = 25000000;
  localparam longint STEP_MS     = 4000;    // 60 s spread over 15 codes
  localparam longint STEP_CYCLES = (CLK_HZ / 1000) * STEP_MS;

  typedef enum logic [2:0] {
    SMC_IDLE  = 3'b001,
    SMC_WAIT  = 3'b010,
    SMC_TRIG  = 3'b100
  } smc_state_t;

  // saturate a signed 33-bit value to 16 bits signed
  function automatic logic [15:0] smc_sat16(input logic signed [32:0] v);
    if (v > 33'sd32767)
      smc_sat16 = 16'h7FFF;
    else if (v < -33'sd32768)
      smc_sat16 = 16'h8000;
    else
      smc_sat16 = v[15:0];
  endfunction
endpackage

// File: hw/smc_correct.sv
`timescale 1ns/1ps
// gain then offset, saturating; registered output
module smc_correct (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_raw,
  input  wire logic [15:0] i_gain,
  input  wire logic [15:0] i_offset,
  output logic             o_valid,
  output logic [15:0]      o_result
);
  import smc_pkg::*;
  logic signed [32:0] prod_w;
  logic signed [32:0] sum_w;
  logic [15:0]        res_q;
  logic               val_q;

  // multiply before adding so the offset is in output units
  assign prod_w = 33'(($signed(i_raw) * $signed({1'b0, i_gain})) >>> GAIN_FRAC);
  assign sum_w  = prod_w + 33'($signed(i_offset));

  // saturate rather than wrap
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      res_q <= 16'h0000;
      val_q <= 1'b0;
    end else begin
      val_q <= i_valid;
      if (i_valid) begin
        res_q <= smc_sat16(sum_w);
      end
    end
  end
  assign o_valid  = val_q;
  assign o_result = res_q;
endmodule

// File: hw/smc_fifo.sv
`timescale 1ns/1ps
// measurement store, stop-when-full or overwrite-oldest
module smc_fifo (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_push,
  input  wire logic [15:0] i_data,
  input  wire logic        i_pop,
  output logic [15:0]      o_data,
  output logic [5:0]       o_count,
  output logic             o_drop
);
  import smc_pkg::*;
  logic [15:0]        mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_q;
  logic [FIFO_AW-1:0] rd_q;
  logic [5:0]         cnt_q;
  logic [15:0]        out_q;
  logic               full_w;
  logic               empty_w;
  logic               en_w;
  logic               do_pop_w;
  logic               do_push_w;
  logic               ovwr_w;

  assign full_w    = (cnt_q == 6'(FIFO_DEPTH));
  assign empty_w   = (cnt_q == 6'h00);
  assign en_w      = (i_mode != SMC_FIFO_OFF);
  assign do_pop_w  = i_pop && !empty_w;
  assign ovwr_w    = full_w && (i_mode == SMC_FIFO_OVWR) && !do_pop_w;
  assign do_push_w = en_w && i_push &&
                     (!full_w || do_pop_w || ovwr_w);

  // writes land at wr_q; overwrite drags the read pointer along
  always_ff @(posedge i_clk) begin
    if (do_push_w) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !en_w) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= 6'h00;
      out_q <= 16'h0000;
    end else begin
      if (do_push_w) wr_q <= wr_q + 1'b1;
      if (do_pop_w || (ovwr_w && i_push)) rd_q <= rd_q + 1'b1;
      if (do_pop_w) out_q <= mem_q[rd_q];
      if (do_push_w && !do_pop_w && !ovwr_w) cnt_q <= cnt_q + 1'b1;
      else if (do_pop_w && !do_push_w) cnt_q <= cnt_q - 1'b1;
    end
  end
  assign o_data  = out_q;
  assign o_count = cnt_q;
  assign o_drop  = en_w && i_push && full_w && !do_pop_w;
endmodule

// File: hw/smc_top.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module smc_top (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  input  wire logic        i_meas_valid,
  input  wire logic [15:0] i_meas_p,
  input  wire logic [15:0] i_meas_t,
  output logic             o_meas_trig,
  output logic [15:0]      o_dac_value,
  output logic             o_dac_buf_cur,
  output logic             o_irq
);
  import smc_pkg::*;

  logic [15:0]        operation_control_q;
  logic [15:0]        dac_q;
  logic [15:0]        pgain_q;
  logic [15:0]        poffs_q;
  logic [15:0]        tgain_q;
  logic [15:0]        toffs_q;
  logic [IRQ_W-1:0]   stat_q;
  logic [IRQ_W-1:0]   stat_d;
  logic [IRQ_W-1:0]   mask_q;
  logic [15:0]        rdata_q;
  logic [15:0]        dac_val_q;
  logic               pin_q;
  logic               thr_hit_q;
  smc_state_t         state_q;
  smc_state_t         state_d;
  logic [31:0]        tmr_q;
  logic [31:0]        tmr_d;

  wire [3:0]          delay_w = operation_control_q[OP_DELAY_LSB +: 4];
  wire [1:0]          fmode_w = operation_control_q[OP_FIFO_MODE +: 2];
  wire [4:0]          thr_w   = operation_control_q[OP_THR_LSB +: 5];
  wire                cont_w  = operation_control_q[OP_INT_CONT];
  wire                upd_w   = operation_control_q[OP_INT_MODE];
  wire                p_vld_w;
  wire                t_vld_w;
  wire [15:0]         p_res_w;
  wire [15:0]         t_res_w;
  wire [15:0]         fifo_dat_w;
  wire [5:0]          fifo_cnt_w;
  wire                fifo_drop_w;
  wire                wr_operation_control_w = i_wr && (i_addr == ADDR_OPERATION_CONTROL_CTRL);
  wire                wr_stat_w = i_wr && (i_addr == ADDR_IRQ_STAT);
  wire                pop_w     = i_rd && (i_addr == ADDR_FIFO_DATA);
  wire [31:0]         period_w  = 32'(delay_w) * 32'(STEP_CYCLES);
  wire                thr_lvl_w;
  wire                thr_rise_w;
  wire [IRQ_W-1:0]    ev_w;

  // pressure and temperature correction lanes
  smc_correct u_p (
    .i_clk    (i_clk),
    .i_reset_n(i_reset_n),
    .i_valid  (i_meas_valid),
    .i_raw    (i_meas_p),
    .i_gain   (pgain_q),
    .i_offset (poffs_q),
    .o_valid  (p_vld_w),
    .o_result (p_res_w)
  );
  smc_correct u_t (
    .i_clk    (i_clk),
    .i_reset_n(i_reset_n),
    .i_valid  (i_meas_valid),
    .i_raw    (i_meas_t),
    .i_gain   (tgain_q),
    .i_offset (toffs_q),
    .o_valid  (t_vld_w),
    .o_result (t_res_w)
  );

  // corrected pressure is what gets stored
  smc_fifo u_fifo (
    .i_clk    (i_clk),
    .i_reset_n(i_reset_n),
    .i_mode   (fmode_w),
    .i_push   (p_vld_w),
    .i_data   (p_res_w),
    .i_pop    (pop_w),
    .o_data   (fifo_dat_w),
    .o_count  (fifo_cnt_w),
    .o_drop   (fifo_drop_w)
  );

  // register writes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      operation_control_q  <= OPERATION_CONTROL_RESET;
      dac_q   <= DAC_RESET;
      pgain_q <= GAIN_ONE;
      poffs_q <= OFFS_ZERO;
      tgain_q <= GAIN_ONE;
      toffs_q <= OFFS_ZERO;
      mask_q  <= '0;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_OPERATION_CONTROL_CTRL: operation_control_q  <= i_wdata;
        ADDR_DAC_CTRL:  dac_q   <= i_wdata;
        ADDR_P_GAIN:    pgain_q <= i_wdata;
        ADDR_P_OFFS:    poffs_q <= i_wdata;
        ADDR_T_GAIN:    tgain_q <= i_wdata;
        ADDR_T_OFFS:    toffs_q <= i_wdata;
        ADDR_IRQ_MASK:  mask_q  <= i_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // threshold level falls as soon as reads drain below it
  assign thr_lvl_w  = (thr_w != 5'h00) &&
                      (fifo_cnt_w >= {1'b0, thr_w});
  assign thr_rise_w = thr_lvl_w && !thr_hit_q;
  assign ev_w[IRQ_FIFO_THR] = thr_rise_w;
  assign ev_w[IRQ_MEAS]     = p_vld_w;
  assign ev_w[IRQ_OVFL]     = fifo_drop_w;

  // update mode keeps only the newest events; or mode accumulates
  always_comb begin
    if (upd_w && (ev_w != '0))
      stat_d = ev_w;
    else
      stat_d = stat_q & ~(wr_stat_w ? i_wdata[IRQ_W-1:0] : '0);
    stat_d = stat_d | ev_w;                                   // set wins
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      stat_q    <= '0;
      thr_hit_q <= 1'b0;
    end else begin
      stat_q    <= stat_d;
      thr_hit_q <= thr_lvl_w;
    end
  end

  // continuous mode follows the level; event mode follows sticky status
  always_ff @(posedge i_clk) begin
    if (!i_reset_n)
      pin_q <= 1'b0;
    else if (cont_w)
      pin_q <= thr_lvl_w && mask_q[IRQ_FIFO_THR];
    else
      pin_q <= |(stat_d & mask_q);
  end
  assign o_irq = pin_q;

  // autonomous interval timer; a whole step is seconds long, so a
  // short test run can only see it stay quiet
  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_q;
    case (state_q)
      SMC_IDLE: begin
        tmr_d = 32'h0000_0000;
        if (delay_w != 4'h0) state_d = SMC_WAIT;
      end
      SMC_WAIT: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (delay_w == 4'h0) state_d = SMC_IDLE;
        else if (tmr_q + 32'h0000_0001 >= period_w) state_d = SMC_TRIG;
      end
      SMC_TRIG: begin
        tmr_d   = 32'h0000_0000;
        state_d = (delay_w == 4'h0) ? SMC_IDLE : SMC_WAIT;
      end
      default: state_d = SMC_IDLE;
    endcase
  end

  // writing operation_control restarts the count so a new code acts at once
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || wr_operation_control_w) begin
      state_q <= SMC_IDLE;
      tmr_q   <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
    end
  end
  assign o_meas_trig = (state_q == SMC_TRIG);

  // dac source select, refreshed on every corrected sample
  always_ff @(posedge i_clk) begin
    if (!i_reset_n)
      dac_val_q <= 16'h0000;
    else if (p_vld_w)
      dac_val_q <= dac_q[DAC_SEL_TEMP] ? t_res_w : p_res_w;
  end
  assign o_dac_value   = dac_val_q;
  assign o_dac_buf_cur = dac_q[DAC_BUF_CUR];

  // read mux; fifo pop data is ready next cycle, matching read latency
  wire [15:0] rmux_w =
    (i_addr == ADDR_OPERATION_CONTROL_CTRL)  ? operation_control_q :
    (i_addr == ADDR_DAC_CTRL)   ? dac_q :
    (i_addr == ADDR_P_GAIN)     ? pgain_q :
    (i_addr == ADDR_P_OFFS)     ? poffs_q :
    (i_addr == ADDR_T_GAIN)     ? tgain_q :
    (i_addr == ADDR_T_OFFS)     ? toffs_q :
    (i_addr == ADDR_IRQ_STAT)   ? 16'(stat_q) :
    (i_addr == ADDR_IRQ_MASK)   ? 16'(mask_q) :
    (i_addr == ADDR_FIFO_LEVEL) ? 16'(fifo_cnt_w) :
    (i_addr == ADDR_P_RESULT)   ? p_res_w :
    (i_addr == ADDR_T_RESULT)   ? t_res_w :
    (i_addr == ADDR_DAC_VALUE)  ? dac_val_q : 16'h0000;
  // a pop answers from the fifo register one cycle later, via pop_q
  logic pop_q;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 16'h0000;
      pop_q   <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rmux_w : 16'h0000;
      pop_q   <= pop_w;
    end
  end
  assign o_rdata = pop_q ? fifo_dat_w : rdata_q;

  // checks; each property names its own clock and reset
  thr_irq_cont_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    cont_w && $stable(cont_w) |->
      o_irq == $past(thr_lvl_w && mask_q[IRQ_FIFO_THR]))
    else $error("continuous pin does not follow threshold level");
  irq_evt_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !cont_w |=> o_irq == $past(|(stat_d & mask_q)))
    else $error("event pin does not follow masked status");
  thr_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    thr_w == 5'h00 |-> !thr_lvl_w)
    else $error("threshold zero still raises level");
  dac_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    p_vld_w |=> o_dac_value == ($past(dac_q[DAC_SEL_TEMP]) ?
      $past(t_res_w) : $past(p_res_w)))
    else $error("dac source wrong");
  buf_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wr && i_addr == ADDR_DAC_CTRL |=>
      o_dac_buf_cur == $past(i_wdata[DAC_BUF_CUR]))
    else $error("buffer select not applied");
  trig_off_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    delay_w == 4'h0 && $past(delay_w) == 4'h0 |-> !o_meas_trig)
    else $error("trigger while interval off");
  corr_lat_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_meas_valid |=> p_vld_w && t_vld_w)
    else $error("correction latency wrong");
  sat_hi_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_meas_valid && u_p.sum_w > 33'sd32767 |=> p_res_w == 16'h7FFF)
    else $error("pressure not saturated high");
  sat_lo_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_meas_valid && u_p.sum_w < -33'sd32768 |=> p_res_w == 16'h8000)
    else $error("pressure not saturated low");
  set_wins_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ev_w[IRQ_MEAS] |=> stat_q[IRQ_MEAS])
    else $error("event lost on clear");
  upd_only_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    upd_w && ev_w != '0 |=> stat_q == $past(ev_w))
    else $error("update mode kept an older event");
  fifo_off_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fmode_w == SMC_FIFO_OFF |=> fifo_cnt_w == 6'h00)
    else $error("fifo stores while off");
  cnt_max_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fifo_cnt_w <= 6'(FIFO_DEPTH))
    else $error("fifo count past depth");
  // main scenarios: trigger, interrupt, drop, overwrite, update mode
  trig_c: cover property (@(posedge i_clk) o_meas_trig);
  irq_c: cover property (@(posedge i_clk) o_irq);
  full_c: cover property (@(posedge i_clk) fifo_drop_w);
  ovwr_c: cover property (@(posedge i_clk)
    fifo_drop_w && fmode_w == SMC_FIFO_OVWR);
  upd_c: cover property (@(posedge i_clk) upd_w && ev_w[IRQ_MEAS]);
endmodule

// File: verification/smc_sensor_model.sv
`timescale 1ns/1ps
// far-side sample source, answers a bench request or an autonomous trigger
module smc_sensor_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_trig,
  input  wire logic [3:0]  i_wait,
  input  wire logic [15:0] i_p,
  input  wire logic [15:0] i_t,
  output logic             o_valid,
  output logic [15:0]      o_p,
  output logic [15:0]      o_t
);
  logic [4:0]  cnt_q = 5'h00;
  logic [15:0] p_q   = 16'h0000;
  logic [15:0] t_q   = 16'h0000;
  // data lines show the inverse outside the valid cycle, so late sampling
  // in the design picks up garbage rather than a lucky stale value
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_p <= ~p_q;
    o_t <= ~t_q;
    if (i_req || i_trig) begin
      cnt_q <= {1'b0, i_wait} + 5'h01;
      p_q <= i_p;
      t_q <= i_t;
    end else if (cnt_q == 5'h01) begin
      o_valid <= 1'b1;
      o_p <= p_q;
      o_t <= t_q;
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// File: verification/tb_sensor_measurement_config.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_sensor_measurement_config;
  import smc_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [15:0] rdata, dac, sp = 16'h0000, st = 16'h0000, mp, mt;
  logic        req = 1'b0;
  logic        valid, trig, buf_cur, irq;
  logic [3:0]  slow = 4'h0;
  int          errors = 0;
  int          checks_done = 0;

  always #20 clk = ~clk;

  smc_top uut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_meas_valid(valid), .i_meas_p(mp), .i_meas_t(mt),
    .o_meas_trig(trig), .o_dac_value(dac), .o_dac_buf_cur(buf_cur),
    .o_irq(irq));
  smc_sensor_model sensor (.i_clk(clk), .i_req(req), .i_trig(trig),
    .i_wait(slow), .i_p(sp), .i_t(st), .o_valid(valid), .o_p(mp),
    .o_t(mt));

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one-cycle strobes launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  // ask the sensor for one sample and let it settle into the dac
  task automatic meas(input logic [15:0] p, input logic [15:0] t);
    int n;
    n = 0;
    @(posedge clk);
    sp <= p;
    st <= t;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (valid !== 1'b1 && n < 40);
    `CHK("sample valid", 1'b1, valid)
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset;
    `CHK("irq", 1'b0, irq)
    `CHK("dac", 16'h0000, dac)
    rchk("operation_control", ADDR_OPERATION_CONTROL_CTRL, OPERATION_CONTROL_RESET);
    rchk("dacctl", ADDR_DAC_CTRL, DAC_RESET);
    rchk("pgain", ADDR_P_GAIN, GAIN_ONE);
    rchk("poffs", ADDR_P_OFFS, OFFS_ZERO);
    rchk("tgain", ADDR_T_GAIN, GAIN_ONE);
    rchk("toffs", ADDR_T_OFFS, OFFS_ZERO);
    wr(4'hD, 16'hFFFF);
    rchk("unmapped", 4'hD, 16'h0000);
  endtask

  // gain first then offset; offset first would give 0x0922
  task automatic t_correct;
    wr(ADDR_P_GAIN, 16'h4000);
    wr(ADDR_P_OFFS, 16'h0010);
    wr(ADDR_T_OFFS, 16'hFFF0);
    slow <= 4'h5;
    meas(16'h1234, 16'h0100);
    slow <= 4'h0;
    rchk("pres", ADDR_P_RESULT, 16'h092A);
    rchk("temp", ADDR_T_RESULT, 16'h00F0);
    `CHK("dac pres", 16'h092A, dac)
    wr(ADDR_DAC_CTRL, 16'h0001);
    meas(16'h1234, 16'h0100);
    `CHK("dac temp", 16'h00F0, dac)
    wr(ADDR_DAC_CTRL, 16'h0002);
    meas(16'h1234, 16'h0100);
    `CHK("dac back", 16'h092A, dac)
    `CHK("buf", 1'b1, buf_cur)
    wr(ADDR_DAC_CTRL, 16'h0000);
    #1;
    `CHK("buf", 1'b0, buf_cur)
    wr(ADDR_P_GAIN, 16'h8000);
    wr(ADDR_P_OFFS, 16'h7000);
    meas(16'h7000, 16'h0000);
    rchk("sat hi", ADDR_P_RESULT, 16'h7FFF);
    wr(ADDR_P_OFFS, 16'h9000);
    meas(16'h9000, 16'h0000);
    rchk("sat lo", ADDR_P_RESULT, 16'h8000);
    wr(ADDR_P_OFFS, 16'h0000);
  endtask

  task automatic t_thresh;
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0007);
    wr(ADDR_OPERATION_CONTROL_CTRL, 16'h0890);
    meas(16'h0011, 16'h0000);
    `CHK("irq lvl1", 1'b0, irq)
    meas(16'h0022, 16'h0000);
    `CHK("irq lvl2", 1'b1, irq)
    rchk("level", ADDR_FIFO_LEVEL, 16'h0002);
    rchk("pop", ADDR_FIFO_DATA, 16'h0011);
    #41;
    `CHK("irq below", 1'b0, irq)
    rchk("status", ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_STAT, 16'h0003);
    rchk("status clr", ADDR_IRQ_STAT, 16'h0000);
    wr(ADDR_OPERATION_CONTROL_CTRL, 16'h0090);
    rchk("pop", ADDR_FIFO_DATA, 16'h0022);
    meas(16'h0033, 16'h0000);
    meas(16'h0044, 16'h0000);
    rchk("pop", ADDR_FIFO_DATA, 16'h0033);
    #41;
    `CHK("irq event", 1'b1, irq)
    wr(ADDR_IRQ_MASK, 16'h0000);
    #41;
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_STAT, 16'h0007);
    wr(ADDR_IRQ_MASK, 16'h0001);
    rchk("pop", ADDR_FIFO_DATA, 16'h0044);
    wr(ADDR_OPERATION_CONTROL_CTRL, 16'h0010);
    meas(16'h0055, 16'h0000);
    meas(16'h0066, 16'h0000);
    rchk("thr off", ADDR_IRQ_STAT, 16'h0002);
    `CHK("irq off", 1'b0, irq)
    rchk("pop", ADDR_FIFO_DATA, 16'h0055);
    rchk("pop", ADDR_FIFO_DATA, 16'h0066);
  endtask

  task automatic t_full;
    wr(ADDR_IRQ_STAT, 16'h0007);
    for (int i = 1; i <= 33; i++)
      meas(16'(i), 16'h0000);
    rchk("full", ADDR_FIFO_LEVEL, 16'h0020);
    rchk("drop", ADDR_IRQ_STAT, 16'h0006);
    rchk("keep old", ADDR_FIFO_DATA, 16'h0001);
    wr(ADDR_OPERATION_CONTROL_CTRL, 16'h0020);
    meas(16'h0100, 16'h0000);
    meas(16'h0200, 16'h0000);
    rchk("overwrite", ADDR_FIFO_DATA, 16'h0003);
    for (int i = 0; i < 31; i++)
      rchk("drain", ADDR_FIFO_DATA, (i < 29) ? 16'(i + 4) :
           ((i == 29) ? 16'h0100 : 16'h0200));
    wr(ADDR_OPERATION_CONTROL_CTRL, 16'h0000);
    meas(16'h0300, 16'h0000);
    rchk("fifo off", ADDR_FIFO_LEVEL, 16'h0000);
  endtask

  // same two samples, combined versus latest-only status
  task automatic t_update;
    logic [15:0] m[2] = '{16'h0050, 16'h1050};
    logic [15:0] e[2] = '{16'h0003, 16'h0002};
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_OPERATION_CONTROL_CTRL, m[k]);
      wr(ADDR_IRQ_STAT, 16'h0007);
      meas(16'h0005, 16'h0000);
      meas(16'h0006, 16'h0000);
      rchk("upd mode", ADDR_IRQ_STAT, e[k]);
      rchk("pop", ADDR_FIFO_DATA, 16'h0005);
      rchk("pop", ADDR_FIFO_DATA, 16'h0006);
    end
  endtask

  // a nonzero code is seconds away, so neither setting may fire soon
  task automatic t_interval;
    int n;
    n = 0;
    // look just after each edge, once the trigger has settled
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_OPERATION_CONTROL_CTRL, 16'(k));
      repeat (300) begin
        @(posedge clk);
        #1;
        n += int'(trig === 1'b1);
      end
    end
    `CHK("trig count", 0, n)
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_correct();
    t_thresh();
    t_full();
    t_update();
    t_interval();
    final_report();
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
